// ### verilog/dac_i2c_write_slave.sv
// Two-wire write-only slave front end and register core of a single DAC
`timescale 1ns/10ps
`default_nettype none
module dac_i2c_write_slave import dac_write_pkg::*; #(
   parameter bit MID_SCALE_RESET = 1'b0,
   parameter int RESOLUTION = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel_pin0_in,
   output logic addr_sel_pin0_out,
   output logic addr_sel_pin0_oe,
   input wire logic addr_sel_pin1_in,
   output logic addr_sel_pin1_out,
   output logic addr_sel_pin1_oe,
   input wire logic addr_sel_pin2_in,
   output logic addr_sel_pin2_out,
   output logic addr_sel_pin2_oe,
   input wire logic async_update_n,
   output dac_state_t dac_state
);
   // ----------------------------------------------------------------
   // Address pin float detection (system domain)
   // ----------------------------------------------------------------
   // Each pin is probed twice: weakly driven high, then low. A pin that
   // follows the probe is floating; one that holds its level is strapped.
   localparam int PROBE_SETTLE = 8;
   logic [2:0] pins_sync;
   logic [3:0] probe_cnt_reg;
   logic probe_phase_reg;
   logic probe_done_reg;
   logic [2:0] seen_high_reg;
   pin_level_t lvl_reg [3];
   logic [6:0] own_addr_reg;
   logic [4:0] index;

   sync3 u_sync_p0 (.clk(clk), .nrst(nrst), .d(addr_sel_pin0_in), .q(pins_sync[0]));
   sync3 u_sync_p1 (.clk(clk), .nrst(nrst), .d(addr_sel_pin1_in), .q(pins_sync[1]));
   sync3 u_sync_p2 (.clk(clk), .nrst(nrst), .d(addr_sel_pin2_in), .q(pins_sync[2]));

   // Probe sequencer; runs once after reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         probe_cnt_reg <= 4'h0;
         probe_phase_reg <= 1'b0;
         probe_done_reg <= 1'b0;
         seen_high_reg <= 3'h0;
      end else if (!probe_done_reg) begin
         probe_cnt_reg <= probe_cnt_reg + 4'h1;
         if (probe_cnt_reg == 4'(PROBE_SETTLE)) begin
            probe_cnt_reg <= 4'h0;
            if (!probe_phase_reg) begin
               seen_high_reg <= pins_sync;
               probe_phase_reg <= 1'b1;
            end else begin
               probe_done_reg <= 1'b1;
            end
         end
      end
   end

   // Classify each pin once probing ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 3; i++) begin
            lvl_reg[i] <= LVL_LOW;
         end
      end else if (probe_done_reg == 1'b0 && probe_phase_reg && probe_cnt_reg == 4'(PROBE_SETTLE)) begin
         for (int i = 0; i < 3; i++) begin
            if (seen_high_reg[i] && !pins_sync[i]) begin
               lvl_reg[i] <= LVL_FLOAT;
            end else if (pins_sync[i]) begin
               lvl_reg[i] <= LVL_HIGH;
            end else begin
               lvl_reg[i] <= LVL_LOW;
            end
         end
      end
   end

   // Probe drive: only during detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_sel_pin0_oe <= 1'b0;
         addr_sel_pin1_oe <= 1'b0;
         addr_sel_pin2_oe <= 1'b0;
         addr_sel_pin0_out <= 1'b0;
         addr_sel_pin1_out <= 1'b0;
         addr_sel_pin2_out <= 1'b0;
      end else begin
         addr_sel_pin0_oe <= !probe_done_reg;
         addr_sel_pin1_oe <= !probe_done_reg;
         addr_sel_pin2_oe <= !probe_done_reg;
         addr_sel_pin0_out <= !probe_phase_reg;
         addr_sel_pin1_out <= !probe_phase_reg;
         addr_sel_pin2_out <= !probe_phase_reg;
      end
   end

   // Own address from the 27-way index
   assign index = 5'(9 * int'(lvl_reg[2]) + 3 * int'(lvl_reg[1]) + int'(lvl_reg[0]));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         own_addr_reg <= 7'h10;
      end else begin
         own_addr_reg <= {3'(index[4:2] + ADDR_HI_BASE), 2'b00, index[1:0]};
      end
   end

   // ----------------------------------------------------------------
   // Link domain: bit receiver on serial clock
   // ----------------------------------------------------------------
   // Start/stop are data edges with the clock high; they are caught on
   // the data line itself and resolved against the clock level. Bits
   // ride on scl_clk edges, which the master only gives inside frames.
   typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} rx_state_t;
   rx_state_t state_reg;
   logic start_tog_reg;
   logic stop_tog_reg;
   logic start_seen_reg;
   logic stop_seen_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [1:0] byte_cnt_reg;
   logic [23:0] word_reg;
   logic ack_reg;
   logic word_tog_reg;
   dac_word_t word_out_reg;
   logic [6:0] own_addr_link;

   // Start: data falls while clock high
   always_ff @(negedge sda_in or negedge nrst) begin
      if (!nrst) begin
         start_tog_reg <= 1'b0;
      end else if (scl_clk) begin
         start_tog_reg <= !start_tog_reg;
      end
   end

   // Stop: data rises while clock high
   always_ff @(posedge sda_in or negedge nrst) begin
      if (!nrst) begin
         stop_tog_reg <= 1'b0;
      end else if (scl_clk) begin
         stop_tog_reg <= !stop_tog_reg;
      end
   end

   // Own address is static after probing; held in link-domain flops
   always_ff @(posedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         own_addr_link <= 7'h10;
      end else begin
         own_addr_link <= own_addr_reg;
      end
   end

   // Receiver: rising clock samples, MSB first
   always_ff @(posedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         start_seen_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_cnt_reg <= 2'h0;
         word_reg <= 24'h000000;
      end else begin
         start_seen_reg <= start_tog_reg;
         stop_seen_reg <= stop_tog_reg;
         if (start_seen_reg != start_tog_reg) begin
            // Fresh frame, any partial word dropped
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h1;
            byte_cnt_reg <= 2'h0;
            shift_reg <= {7'h00, sda_in};
         end else if (stop_seen_reg != stop_tog_reg) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
         end else if (state_reg != ST_IDLE) begin
            if (bit_cnt_reg == 4'(BYTE_BITS)) begin
               bit_cnt_reg <= 4'h0; // ninth clock
               case (state_reg)
                  ST_ADDR: begin
                     if (ack_reg) begin
                        state_reg <= ST_DATA;
                     end else begin
                        state_reg <= ST_IGNORE;
                     end
                  end
                  ST_DATA: begin
                     word_reg <= {word_reg[15:0], shift_reg};
                     if (byte_cnt_reg == 2'(DATA_BYTES - 1)) begin
                        state_reg <= ST_IGNORE;
                     end
                     byte_cnt_reg <= byte_cnt_reg + 2'h1;
                  end
                  default: ;
               endcase
            end else begin
               shift_reg <= {shift_reg[6:0], sda_in};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end
      end
   end

   // Ack decision made on falling clock so data is settled by the ninth high
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         ack_reg <= 1'b0;
      end else if (bit_cnt_reg == 4'(BYTE_BITS)) begin
         if (state_reg == ST_ADDR) begin
            ack_reg <= !shift_reg[RW_BIT_POS] &&
                       (shift_reg[7:1] == own_addr_link || shift_reg[7:1] == GLOBAL_ADDR);
         end else begin
            ack_reg <= (state_reg == ST_DATA);
         end
      end else if (bit_cnt_reg == 4'h0) begin
         ack_reg <= 1'b0; // release after the ninth clock
      end
   end

   // Data line: pull low only while acknowledging, never drive high
   assign sda_out = 1'b0;
   assign sda_oe = ack_reg;

   // Completed word posted on the ninth-clock fall of the third byte;
   // the update pin is read at that very fall, scl being too sparse to chain
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         word_tog_reg <= 1'b0;
         word_out_reg <= '0;
      end else if (state_reg == ST_IGNORE && byte_cnt_reg == 2'(DATA_BYTES) && bit_cnt_reg == 4'h0 && ack_reg) begin
         word_out_reg.cmd <= word_reg[16 + CMD_MSB:16 + CMD_LSB];
         word_out_reg.data <= word_reg[15:0];
         word_out_reg.pd_inhibit <= !async_update_n;
         word_tog_reg <= !word_tog_reg;
      end
   end

   // ----------------------------------------------------------------
   // System domain: command execution
   // ----------------------------------------------------------------
   logic word_tog_sync;
   logic word_tog_seen_reg;
   logic upd_n_sync;
   logic upd_n_prev_reg;
   logic word_ready_reg;
   logic [15:0] input_reg;
   logic [15:0] dac_reg;
   logic pwrdn_reg;
   logic [15:0] code_mask;
   logic word_event;
   logic upd_fall;

   sync3 u_sync_word (.clk(clk), .nrst(nrst), .d(word_tog_reg), .q(word_tog_sync));
   sync3 #(.RESET_VAL(1'b1)) u_sync_upd (.clk(clk), .nrst(nrst), .d(async_update_n), .q(upd_n_sync));

   // Trailing bits below resolution are ignored
   assign code_mask = 16'hffff << (16 - RESOLUTION);
   assign word_event = (word_tog_sync != word_tog_seen_reg);
   assign upd_fall = upd_n_prev_reg && !upd_n_sync;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_tog_seen_reg <= 1'b0;
         upd_n_prev_reg <= 1'b1;
      end else begin
         word_tog_seen_reg <= word_tog_sync;
         upd_n_prev_reg <= upd_n_sync;
      end
   end

   // A complete word arms the async update; a new frame start does not clear it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_ready_reg <= 1'b0;
      end else if (word_event) begin
         word_ready_reg <= 1'b1;
      end
   end

   // Input register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         input_reg <= MID_SCALE_RESET ? CODE_MID_SCALE : CODE_ZERO_SCALE;
      end else if (word_event && (word_out_reg.cmd == CMD_WRITE || word_out_reg.cmd == CMD_WRITE_UPDATE)) begin
         input_reg <= word_out_reg.data & code_mask;
      end
   end

   // DAC register and power-down; the word is stable while its toggle syncs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac_reg <= MID_SCALE_RESET ? CODE_MID_SCALE : CODE_ZERO_SCALE;
         pwrdn_reg <= PWRDN_RESET;
      end else if (word_event) begin
         case (word_out_reg.cmd)
            CMD_UPDATE: begin
               dac_reg <= input_reg;
               pwrdn_reg <= 1'b0;
            end
            CMD_WRITE_UPDATE: begin
               dac_reg <= word_out_reg.data & code_mask;
               pwrdn_reg <= 1'b0;
            end
            CMD_POWER_DOWN: begin
               pwrdn_reg <= !word_out_reg.pd_inhibit;
            end
            default: begin
               dac_reg <= upd_fall && word_ready_reg ? input_reg : dac_reg;
               pwrdn_reg <= upd_fall ? 1'b0 : pwrdn_reg;
            end
         endcase
      end else if (upd_fall) begin
         pwrdn_reg <= 1'b0;
         if (word_ready_reg) begin
            dac_reg <= input_reg;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dac_state <= {MID_SCALE_RESET ? CODE_MID_SCALE : CODE_ZERO_SCALE,
                       MID_SCALE_RESET ? CODE_MID_SCALE : CODE_ZERO_SCALE, PWRDN_RESET};
      end else begin
         dac_state.input_code <= input_reg;
         dac_state.dac_code <= dac_reg;
         dac_state.powered_down <= pwrdn_reg;
      end
   end
endmodule : dac_i2c_write_slave
`default_nettype wire

// ### verilog/dac_write_pkg.sv
// Package: constants and types for the two-wire DAC write slave
package dac_write_pkg;

   // ----------------------------------------------------------------
   // Addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] GLOBAL_ADDR = 7'h73;
   localparam logic [2:0] ADDR_HI_BASE = 3'h1;
   localparam int ADDR_PIN_LEVELS = 3;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int DATA_BYTES = 3;
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 4;
   localparam int RW_BIT_POS = 0;

   // ----------------------------------------------------------------
   // Commands and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_UPDATE = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
   localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
   localparam logic [3:0] CMD_NOP = 4'hf;
   localparam logic [15:0] CODE_ZERO_SCALE = 16'h0000;
   localparam logic [15:0] CODE_MID_SCALE = 16'h8000;
   localparam logic PWRDN_RESET = 1'b0;

   // Tri-level pin reading: low, float, high
   typedef enum logic [1:0] {LVL_LOW, LVL_FLOAT, LVL_HIGH} pin_level_t;

   // Completed word handed from the link domain to the system domain
   typedef struct packed {
      logic [3:0] cmd;
      logic [15:0] data;
      logic pd_inhibit;
   } dac_word_t;

   // Outputs of the converter core
   typedef struct packed {
      logic [15:0] input_code;
      logic [15:0] dac_code;
      logic powered_down;
   } dac_state_t;

endpackage : dac_write_pkg

// ### verilog/sync3.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module sync3 import dac_write_pkg::*; #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Chain; first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Output moves only when second and third stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         q <= s3_reg;
      end
   end
endmodule : sync3
`default_nettype wire

// ### test/dac_write_sva.sv
// Port-level assertion checker for the two-wire DAC write slave
`timescale 1ns/10ps
`default_nettype none
module dac_write_sva import dac_write_pkg::*; #(
   parameter bit MID_SCALE_RESET = 1'b0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_clk,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_sel_pin0_oe,
   input wire logic async_update_n,
   input wire dac_state_t dac_state
);
   localparam logic [15:0] RST_CODE = MID_SCALE_RESET ? CODE_MID_SCALE : CODE_ZERO_SCALE;

   // Reset holds the data and pin0 drivers off and the codes at the build value
   property p_rst_quiet;
      @(posedge clk) !nrst |-> !sda_oe && !addr_sel_pin0_oe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("pin driven in reset");
   property p_rst_code;
      @(posedge clk) !nrst |-> dac_state == {RST_CODE, RST_CODE, 1'b0};
   endproperty
   a_rst_code: assert property (p_rst_code) else $error("reset code wrong");

   // Open drain: only ever pulls low
   property p_open_drain;
      @(posedge clk) disable iff (!nrst) sda_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");

   // Ack spans exactly one clock, then eight bit times stay released
   property p_ack_one;
      @(negedge scl_clk) disable iff (!nrst) sda_oe |=> !sda_oe;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one clock");
   property p_ack_gap;
      @(negedge scl_clk) disable iff (!nrst) $fell(sda_oe) |-> !sda_oe [*8];
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("ack inside a byte");

   // Output code only ever comes from the input register, and wakes the converter
   property p_dac_from_input;
      @(posedge clk) disable iff (!nrst) !$stable(dac_state.dac_code) |-> dac_state.dac_code == dac_state.input_code;
   endproperty
   a_dac_from_input: assert property (p_dac_from_input) else $error("dac code not from input");
   property p_update_wakes;
      @(posedge clk) disable iff (!nrst) !$stable(dac_state.dac_code) |-> !dac_state.powered_down;
   endproperty
   a_update_wakes: assert property (p_update_wakes) else $error("update left power-down");

   // Power-down touches neither register, and is blocked while async update is low
   property p_pd_keeps;
      @(posedge clk) disable iff (!nrst)
         $rose(dac_state.powered_down) |-> $stable(dac_state.input_code) && $stable(dac_state.dac_code);
   endproperty
   a_pd_keeps: assert property (p_pd_keeps) else $error("power-down changed a code");
   property p_pd_blocked;
      @(posedge clk) disable iff (!nrst)
         !async_update_n && !$past(async_update_n, 8) |-> !$rose(dac_state.powered_down);
   endproperty
   a_pd_blocked: assert property (p_pd_blocked) else $error("power-down while async low");

   c_ack: cover property (@(negedge scl_clk) disable iff (!nrst) sda_oe);
   c_pd: cover property (@(posedge clk) disable iff (!nrst) $rose(dac_state.powered_down));
   c_wake: cover property (@(posedge clk) disable iff (!nrst) $fell(dac_state.powered_down));
endmodule : dac_write_sva
`default_nettype wire

// ### test/i2c_master_model.sv
// Two-wire bus master model: makes the serial clock only inside frames
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   // Both lines released high while idle
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Data falls while clock high
   task start;
      sda_drv = 1'b1;
      scl = 1'b1;
      #15 sda_drv = 1'b0;
      #15 scl = 1'b0;
   endtask : start

   // Data rises while clock high, bus then left free
   task stop;
      #5 sda_drv = 1'b0;
      #10 scl = 1'b1;
      #15 sda_drv = 1'b1;
      #60;
   endtask : stop

   // Data moves 5 ns after the fall so it never looks like start or stop
   task wbyte(input logic [7:0] b, output logic ack);
      int i;
      for (i = 7; i >= 0; i--) begin
         #5 sda_drv = b[i];
         #10 scl = 1'b1;
         #15 scl = 1'b0;
      end
      #5 sda_drv = 1'b1;
      #10 scl = 1'b1;
      ack = (sda_line === 1'b0);
      #15 ack = ack && (sda_line === 1'b0); // low at both the start and the end of the high time
      scl = 1'b0;
   endtask : wbyte
endmodule : i2c_master_model
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the two-wire DAC write slave
`timescale 1ns/10ps
`default_nettype none
module tb import dac_write_pkg::*;;
   localparam logic [6:0] OWN_ADDR = 7'h43; // pin2 float, pin1 high, pin0 low
   logic clk, nrst, scl, sda_m, async_n, sda_out, sda_oe;
   logic p0_out, p0_oe, p1_out, p1_oe, p2_out, p2_oe, p2_in;
   wire sda_line;
   dac_state_t st;
   int n_errors, cmp_count;

   // Pull-up on data; the floating pin follows the probe, else shows its inverse
   assign sda_line = sda_m & ~sda_oe;
   assign p2_in = p2_oe ? p2_out : ~p2_out;

   i2c_master_model m (.scl(scl), .sda_drv(sda_m), .sda_line(sda_line));

   dac_i2c_write_slave #(.MID_SCALE_RESET(1'b0), .RESOLUTION(16)) dut (
      .clk(clk), .nrst(nrst), .scl_clk(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel_pin0_in(1'b0), .addr_sel_pin0_out(p0_out), .addr_sel_pin0_oe(p0_oe),
      .addr_sel_pin1_in(1'b1), .addr_sel_pin1_out(p1_out), .addr_sel_pin1_oe(p1_oe),
      .addr_sel_pin2_in(p2_in), .addr_sel_pin2_out(p2_out), .addr_sel_pin2_oe(p2_oe),
      .async_update_n(async_n), .dac_state(st));

   // System clock, 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic dac_state_t mk(input logic [15:0] i, input logic [15:0] d, input logic p);
      mk = {i, d, p};
   endfunction : mk

   task chk_st(input dac_state_t e);
      cmp_count++;
      if (st !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, st, e);
      end
   endtask : chk_st

   task chk_ack(input logic got, input logic e);
      cmp_count++;
      if (got !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, e);
      end
   endtask : chk_ack

   // Bounded wait for the word to cross; looks on the falling edge, clear of the launch
   task settle(input dac_state_t e);
      int i;
      for (i = 0; i < 30 && st !== e; i++) @(negedge clk);
      chk_st(e);
      if (st !== e) give_verdict();
   endtask : settle

   // Nothing should move: give the crossing time, then look
   task hold_chk(input dac_state_t e);
      repeat (12) @(negedge clk);
      chk_st(e);
   endtask : hold_chk

   // ea[4] is the address ack, ea[3:0] the data byte acks in order
   task frame(input logic [6:0] a, input logic rw, input logic [23:0] w, input int n, input logic [4:0] ea);
      logic ack;
      int k;
      m.start();
      m.wbyte({a, rw}, ack);
      chk_ack(ack, ea[4]);
      for (k = 0; k < n; k++) begin
         m.wbyte(k < 3 ? w[23 - 8 * k -: 8] : 8'h5a, ack);
         chk_ack(ack, ea[3 - k]);
      end
      m.stop();
   endtask : frame

   task t_write_update;
      frame(OWN_ADDR, 1'b0, {CMD_WRITE, 4'hc, 16'h1234}, 3, 5'b11110);
      settle(mk(16'h1234, 16'h0000, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_UPDATE, 4'h0, 16'h1234}, 3, 5'b11110);
      settle(mk(16'h1234, 16'h1234, 1'b0));
   endtask : t_write_update

   task t_power;
      frame(OWN_ADDR, 1'b0, {CMD_POWER_DOWN, 4'h0, 16'hffff}, 3, 5'b11110);
      settle(mk(16'h1234, 16'h1234, 1'b1));
      frame(GLOBAL_ADDR, 1'b0, {CMD_WRITE_UPDATE, 4'h0, 16'habcd}, 3, 5'b11110);
      settle(mk(16'habcd, 16'habcd, 1'b0));
   endtask : t_power

   task t_ignored;
      frame(OWN_ADDR, 1'b0, {4'h7, 4'h0, 16'h1111}, 3, 5'b11110);
      hold_chk(mk(16'habcd, 16'habcd, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_NOP, 4'h0, 16'h2222}, 3, 5'b11110);
      hold_chk(mk(16'habcd, 16'habcd, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_WRITE, 4'h0, 16'h0bad}, 2, 5'b11100);
      hold_chk(mk(16'habcd, 16'habcd, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_WRITE, 4'h0, 16'h2468}, 3, 5'b11110);
      settle(mk(16'h2468, 16'habcd, 1'b0));
   endtask : t_ignored

   task t_refuse;
      frame(OWN_ADDR, 1'b1, 24'h0, 1, 5'b00000);
      frame(7'h44, 1'b0, {CMD_WRITE_UPDATE, 4'h0, 16'h7777}, 3, 5'b00000);
      hold_chk(mk(16'h2468, 16'habcd, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_WRITE, 4'h0, 16'h3579}, 4, 5'b11110);
      settle(mk(16'h3579, 16'habcd, 1'b0));
   endtask : t_refuse

   // Async update after a complete word, then power-down while it is held low
   task t_async;
      @(posedge clk);
      async_n <= 1'b0;
      settle(mk(16'h3579, 16'h3579, 1'b0));
      frame(OWN_ADDR, 1'b0, {CMD_POWER_DOWN, 4'h0, 16'h0000}, 3, 5'b11110);
      hold_chk(mk(16'h3579, 16'h3579, 1'b0));
      @(posedge clk);
      async_n <= 1'b1;
   endtask : t_async

   // Mid-run reset: codes fall back to the build value, pins are probed again
   task t_rerun;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(negedge clk);
      chk_st(mk(16'h0000, 16'h0000, 1'b0));
      @(posedge clk);
      nrst <= 1'b1;
      repeat (25) @(posedge clk);
      frame(OWN_ADDR, 1'b0, {CMD_WRITE_UPDATE, 4'h0, 16'h5555}, 3, 5'b11110);
      settle(mk(16'h5555, 16'h5555, 1'b0));
   endtask : t_rerun

   task give_verdict;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // Main sequence: reset, settle the pin probe, then the scenarios
   initial begin
      nrst = 1'b0;
      async_n = 1'b1;
      n_errors = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      chk_st(mk(16'h0000, 16'h0000, 1'b0));
      nrst <= 1'b1;
      repeat (25) @(posedge clk);
      t_write_update();
      t_power();
      t_ignored();
      t_refuse();
      t_async();
      t_rerun();
      give_verdict();
   end
endmodule : tb

bind dac_i2c_write_slave dac_write_sva #(.MID_SCALE_RESET(MID_SCALE_RESET)) u_sva (.clk(clk), .nrst(nrst),
   .scl_clk(scl_clk), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin0_oe(addr_sel_pin0_oe),
   .async_update_n(async_update_n), .dac_state(dac_state));
`default_nettype wire
